// ===== ahbp_int_model.sv
// Purpose: Internal arbiter and storage behind the host port request side
// Assumes: One request at a time, held until grant and ack are seen
// Notes:   Read data is scrambled whenever no answer is due
`timescale 1ns/1ps
module ahbp_int_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        int_req,
  input  wire logic        int_is_mem,
  input  wire logic        int_write,
  input  wire logic [17:0] int_addr,
  input  wire logic [15:0] int_wdata,
  input  wire logic [1:0]  int_byte_en,
  input  wire logic [4:0]  dly,
  output logic             int_grant,
  output logic             int_ack,
  output logic      [15:0] int_rdata
);
  logic [15:0] mem_q [64];
  logic [4:0]  cnt_ff;
  logic        done_ff;
  logic [5:0]  idx;

  assign idx = {int_is_mem, int_addr[5:1]};

  // Grant late on purpose, standing in for refresh contention
  always @(posedge clk_sys) begin
    int_grant <= 1'b0;
    int_ack   <= 1'b0;
    int_rdata <= ~int_rdata; // Stale data never looks valid
    if (!rst_n || !int_req) begin
      cnt_ff  <= 5'h00;
      done_ff <= 1'b0;
    end else if (!done_ff && cnt_ff == dly) begin
      int_grant <= 1'b1;
      int_ack   <= 1'b1;
      done_ff   <= 1'b1;
      int_rdata <= mem_q[idx];
      if (int_write && int_byte_en[0]) mem_q[idx][7:0] <= int_wdata[7:0];
      if (int_write && int_byte_en[1]) mem_q[idx][15:8] <= int_wdata[15:8];
    end else if (!done_ff) begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end
endmodule // ahbp_int_model

// ===== ahbp_pkg.sv
// Purpose: Shared constants and types for the asynchronous host bus port
// Assumes: One system clock at 25 MHz, synchronous active-low reset
// Notes:   Address map, strap positions and sequencing constants live here
package ahbp_pkg;

  // Strap positions in the latched seven-bit configuration word
  localparam int unsigned STRAP_W          = 7;
  localparam int unsigned STRAP_POS_MODE0  = 0;
  localparam int unsigned STRAP_POS_MODE1  = 1;
  localparam int unsigned STRAP_POS_MODE2  = 2;
  localparam int unsigned STRAP_POS_RSVD   = 3;
  localparam int unsigned STRAP_POS_MODE4  = 4;
  localparam int unsigned STRAP_POS_HOLD   = 5;
  localparam int unsigned STRAP_POS_CLKDIV = 6;
  localparam logic [3:0]  STRAP_MODE_SEP_STROBE = 4'h4; // Straps 4,2,1,0 = 0 1 0 0
  localparam logic [6:0]  STRAP_RESET_VAL       = 7'h08;

  // Address map
  localparam int unsigned ADDR_W           = 18;
  localparam int unsigned DATA_W           = 16;
  localparam logic [17:0] REG_LAST_OFS     = 18'h3_FFF;
  localparam logic [19:0] MEM_FIRST_ADDR   = 20'h4_0000;
  localparam logic [19:0] MEM_LAST_ADDR    = 20'h6_8000;
  localparam logic [17:0] BLOCK_BYTES_M1   = 18'h3_FFFF; // 256K byte block

  // Synchroniser depth and reset values
  localparam int unsigned SYNC_STAGES      = 2;
  localparam logic [15:0] DATA_RESET_VAL   = 16'h0000;

  // Access sequencing states
  typedef enum logic [2:0] {
    AHBP_IDLE  = 3'b000,
    AHBP_REQ   = 3'b001,
    AHBP_DONE  = 3'b010,
    AHBP_ENDW  = 3'b011
  } ahbp_state_t;

  // Target of a decoded access
  typedef enum logic [1:0] {
    AHBP_TGT_NONE = 2'b00,
    AHBP_TGT_REG  = 2'b01,
    AHBP_TGT_MEM  = 2'b10
  } ahbp_tgt_t;

endpackage : ahbp_pkg

// ===== ahbp_port.sv
// Purpose: Asynchronous 16-bit host bus port, select plus separate strobes
// Assumes: Host strobes asynchronous; straps steady around reset release
// Notes:   Internal clients answer through a request/grant/ack handshake
//
// Summary of operation
// - Seven straps latched at reset release fix configuration until next reset
// - Straps 4,2,1,0 = 0100 select separate-strobe mode, little endian
// - Wait output active high when strap five is 1, else active low
// - Bus clock enable divides input clock 2:1 if strap six high, else 1:1
// - Host clock input sources internal bus and memory clock enables
// - Host decodes select; device answers only while select is asserted
// - Space select low routes to registers, high to display buffer
// - Registers decode 0h-3FFFh; display memory 40000h-68000h
// - High byte strobe enables upper data byte on reads and writes
// - Wait release marks read data valid or write data accepted
// - Wait held while arbitration has not yet granted the host
// - Host controls are synchronised before use
// - Only eighteen address bits and space select decode; 256K aliasing
`timescale 1ns/1ps
module ahbp_port (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        host_clock_in,
  input  wire logic [6:0]  strap_in,
  input  wire logic        dev_select_n,
  input  wire logic        mem_reg_sel,
  input  wire logic [17:0] host_address_in,
  input  wire logic [15:0] host_data_bus_in,
  output logic      [15:0] host_data_bus_out,
  output logic      [15:0] host_data_bus_oe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        low_write_strobe_n,
  input  wire logic        high_byte_enable_n,
  input  wire logic        bus_start_n,
  input  wire logic        rd_wr_dir,
  output logic             wait_out,
  output logic             wait_oe_n,
  output logic             mode_valid,
  output logic             bus_clk_en,
  output logic             mem_clk_en,
  output logic             int_req,
  output logic             int_is_mem,
  output logic             int_write,
  output logic      [17:0] int_addr,
  output logic      [15:0] int_wdata,
  output logic      [1:0]  int_byte_en,
  input  wire logic        int_grant,
  input  wire logic        int_ack,
  input  wire logic [15:0] int_rdata
);

  ahbp_sync_if sync ();

  // Host controls cross into the system clock domain here
  ahbp_sync i_ahbp_sync (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .dev_select_n       (dev_select_n),
    .read_strobe_n      (read_strobe_n),
    .low_write_strobe_n (low_write_strobe_n),
    .high_byte_enable_n (high_byte_enable_n),
    .sync               (sync)
  );

  typedef struct packed {
    logic                      rst_seen;
    logic [6:0]                straps;
    logic                      div_ph;
    logic                      hclk_d;
    ahbp_pkg::ahbp_state_t     state;
    logic                      is_mem;
    logic                      is_wr;
    logic                      in_map;
    logic [17:0]               addr;
    logic [15:0]               wdata;
    logic [1:0]                be;
    logic [15:0]               rdata;
    logic                      drive;
    logic                      waiting;
  } ahbp_st_t;

  ahbp_st_t st_ff;
  ahbp_st_t nxt_st;

  // Decode against the map; higher host bits never reach this port
  function automatic logic addr_in_map(input logic msel, input logic [17:0] a);
    logic [19:0] full;
    full = {1'b0, msel, a};
    if (!msel) begin
      addr_in_map = (a <= ahbp_pkg::REG_LAST_OFS);
    end else begin
      addr_in_map = (full >= ahbp_pkg::MEM_FIRST_ADDR) &&
                    (full <= ahbp_pkg::MEM_LAST_ADDR);
    end
  endfunction

  logic       hold_pol;
  logic       mode_ok;
  logic       hclk_rise;
  logic       strobe;
  logic [3:0] mode_bits;

  assign hold_pol  = st_ff.straps[ahbp_pkg::STRAP_POS_HOLD];
  assign mode_bits = {st_ff.straps[ahbp_pkg::STRAP_POS_MODE4],
                      st_ff.straps[ahbp_pkg::STRAP_POS_MODE2],
                      st_ff.straps[ahbp_pkg::STRAP_POS_MODE1],
                      st_ff.straps[ahbp_pkg::STRAP_POS_MODE0]};
  assign mode_ok   = (mode_bits == ahbp_pkg::STRAP_MODE_SEP_STROBE);
  // Held off until the delay flop has a real sample: no enables in reset, no false rise after it
  assign hclk_rise = host_clock_in && !st_ff.hclk_d && st_ff.rst_seen;
  assign strobe    = sync.rd || sync.wr;

  // Next-state logic: strap capture, clock enables and the access sequence
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.rst_seen = 1'b1;
    nxt_st.hclk_d   = host_clock_in;
    // Straps are taken on the first clock after reset release only
    if (!st_ff.rst_seen) begin
      nxt_st.straps = strap_in;
    end
    if (hclk_rise) begin
      nxt_st.div_ph = ~st_ff.div_ph;
    end
    case (st_ff.state)
      ahbp_pkg::AHBP_IDLE: begin
        nxt_st.drive   = 1'b0;
        nxt_st.waiting = 1'b0;
        // Bus-start and direction pins play no part in starting a cycle
        if (mode_ok && sync.sel && strobe) begin
          nxt_st.is_mem  = mem_reg_sel;
          nxt_st.addr    = host_address_in;
          nxt_st.is_wr   = sync.wr;
          nxt_st.wdata   = host_data_bus_in;
          nxt_st.be      = {sync.hbe, 1'b1};
          nxt_st.in_map  = addr_in_map(mem_reg_sel, host_address_in);
          nxt_st.waiting = 1'b1;
          nxt_st.state   = ahbp_pkg::AHBP_REQ;
        end
      end
      ahbp_pkg::AHBP_REQ: begin
        // Unmapped accesses finish at once with zero read data
        if (!st_ff.in_map) begin
          nxt_st.rdata   = ahbp_pkg::DATA_RESET_VAL;
          nxt_st.drive   = !st_ff.is_wr;
          nxt_st.waiting = 1'b0;
          nxt_st.state   = ahbp_pkg::AHBP_DONE;
        end else if (int_grant && int_ack) begin
          nxt_st.rdata   = int_rdata;
          nxt_st.drive   = !st_ff.is_wr;
          nxt_st.waiting = 1'b0;
          nxt_st.state   = ahbp_pkg::AHBP_DONE;
        end
        // Host dropped the cycle early: abandon without answering
        if (!sync.sel || !strobe) begin
          nxt_st.waiting = 1'b0;
          nxt_st.drive   = 1'b0;
          nxt_st.state   = ahbp_pkg::AHBP_ENDW;
        end
      end
      ahbp_pkg::AHBP_DONE: begin
        // Data stays on the bus until the host lets go
        if (!sync.sel || !strobe) begin
          nxt_st.drive = 1'b0;
          nxt_st.state = ahbp_pkg::AHBP_IDLE;
        end
      end
      ahbp_pkg::AHBP_ENDW: begin
        nxt_st.state = ahbp_pkg::AHBP_IDLE;
      end
      default: begin
        nxt_st.state = ahbp_pkg::AHBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff        <= '0;
      st_ff.straps <= ahbp_pkg::STRAP_RESET_VAL;
      st_ff.state  <= ahbp_pkg::AHBP_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs; wait polarity follows the latched strap
  assign wait_out   = st_ff.waiting ? hold_pol : ~hold_pol;
  assign wait_oe_n  = ~(st_ff.waiting || (st_ff.state == ahbp_pkg::AHBP_DONE));
  assign mode_valid = st_ff.rst_seen && mode_ok;
  // 2:1 fires on alternate host clock rises, 1:1 on each rise
  assign bus_clk_en = hclk_rise &&
                      (!st_ff.straps[ahbp_pkg::STRAP_POS_CLKDIV] || st_ff.div_ph);
  assign mem_clk_en = hclk_rise;
  assign int_req    = (st_ff.state == ahbp_pkg::AHBP_REQ) && st_ff.in_map;
  assign int_is_mem = st_ff.is_mem;
  assign int_write  = st_ff.is_wr;
  assign int_addr   = st_ff.addr;
  assign int_wdata  = st_ff.wdata;
  assign int_byte_en = st_ff.be;
  assign host_data_bus_out  = st_ff.rdata;
  // Upper lane drives only when the high byte strobe was present
  assign host_data_bus_oe_n = {{8{~(st_ff.drive && st_ff.be[1])}},
                               {8{~st_ff.drive}}};

  // Assertions
  sequence s_start;
    $rose(st_ff.state == ahbp_pkg::AHBP_REQ);
  endsequence

  property p_wait_pol;
    @(posedge clk_sys) disable iff (!rst_n)
    st_ff.waiting |-> (wait_out == hold_pol);
  endproperty
  a_wait_pol: assert property (p_wait_pol) else $error("wait polarity wrong");

  property p_sel_needed;
    @(posedge clk_sys) disable iff (!rst_n)
    (st_ff.state == ahbp_pkg::AHBP_IDLE && !sync.sel) |=> (st_ff.state == ahbp_pkg::AHBP_IDLE);
  endproperty
  a_sel_needed: assert property (p_sel_needed) else $error("cycle without select");

  property p_wait_on_start;
    @(posedge clk_sys) disable iff (!rst_n)
    s_start |-> st_ff.waiting;
  endproperty
  a_wait_on_start: assert property (p_wait_on_start) else $error("no wait at start");

  property p_hold_until_grant;
    @(posedge clk_sys) disable iff (!rst_n)
    (int_req && !int_grant && sync.sel && strobe) |=> st_ff.waiting;
  endproperty
  a_hold_until_grant: assert property (p_hold_until_grant) else $error("wait dropped early");

  property p_read_data;
    @(posedge clk_sys) disable iff (!rst_n)
    (int_req && int_grant && int_ack && !st_ff.is_wr && sync.sel && strobe)
      |=> (!st_ff.waiting && host_data_bus_out == $past(int_rdata) && !host_data_bus_oe_n[0]);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not valid");

  property p_hi_lane;
    @(posedge clk_sys) disable iff (!rst_n)
    (st_ff.drive && !st_ff.be[1]) |-> (host_data_bus_oe_n[15:8] == 8'hFF);
  endproperty
  a_hi_lane: assert property (p_hi_lane) else $error("upper lane driven");

  property p_strap_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    $past(st_ff.rst_seen) |-> $stable(st_ff.straps);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("straps changed");

  property p_div2;
    @(posedge clk_sys) disable iff (!rst_n)
    (bus_clk_en && st_ff.straps[ahbp_pkg::STRAP_POS_CLKDIV]) |=> !bus_clk_en;
  endproperty
  a_div2: assert property (p_div2) else $error("divide ratio wrong");

  property p_space;
    @(posedge clk_sys) disable iff (!rst_n)
    s_start |-> (int_is_mem == $past(mem_reg_sel));
  endproperty
  a_space: assert property (p_space) else $error("space select wrong");

endmodule // ahbp_port

// ===== ahbp_port_tb_top.sv
// Purpose: Self-checking bench for the asynchronous host bus port
// Assumes: Host side driven here, internal side by the partner model
// Notes:   Reads are scored by a monitor against a queue of notes
`timescale 1ns/1ps
module ahbp_port_tb_top;
  typedef struct packed {logic [15:0] d; logic [15:0] oe;} ahbp_exp_t;
  logic        clk_sys = 0, rst_n = 0, hclk = 0, sel_n = 1, mrs = 0, rd_n = 1, wr_n = 1;
  logic        hbe_n = 1, act = 0, prev_oe = 1;
  logic [6:0]  strap = 7'h08;
  logic [17:0] adr = 18'h0_0000;
  logic [15:0] wd = 16'h0000, host_data_bus_out, host_data_bus_oe_n, int_rdata, int_wdata;
  logic [4:0]  dly = 5'h00;
  logic        wait_out, wait_oe_n, mode_valid, bus_clk_en, mem_clk_en;
  logic        int_req, int_is_mem, int_write, int_grant, int_ack;
  logic [17:0] int_addr;
  logic [1:0]  int_byte_en;
  logic [15:0] sh [int];
  logic [18:0] al [4] = '{19'h0_0010, 19'h0_3ffe, 19'h4_0002, 19'h6_8000};
  logic [6:0]  cf [3] = '{7'h2c, 7'h4c, 7'h1c};
  ahbp_exp_t   exp_q [$];
  ahbp_exp_t   e;
  int          fails = 0, tests_run = 0, seed = 32'hc5bd3ca2, hc = 0;

  initial forever #20 clk_sys = ~clk_sys;

  // Host clock at a quarter of the system clock
  always @(posedge clk_sys) begin
    hc <= hc + 1;
    if (hc[0]) hclk <= ~hclk;
  end

  ahbp_port i_ahbp_port (.clk_sys, .rst_n, .host_clock_in(hclk), .strap_in(strap),
    .dev_select_n(sel_n), .mem_reg_sel(mrs), .host_address_in(adr), .host_data_bus_in(wd),
    .host_data_bus_out, .host_data_bus_oe_n, .read_strobe_n(rd_n), .low_write_strobe_n(wr_n),
    .high_byte_enable_n(hbe_n), .bus_start_n(1'b1), .rd_wr_dir(1'b1),
    .wait_out, .wait_oe_n, .mode_valid, .bus_clk_en, .mem_clk_en, .int_req, .int_is_mem,
    .int_write, .int_addr, .int_wdata, .int_byte_en, .int_grant, .int_ack, .int_rdata);
  ahbp_int_model i_ahbp_int_model (.clk_sys, .rst_n, .int_req, .int_is_mem, .int_write,
    .int_addr, .int_wdata, .int_byte_en, .dly, .int_grant, .int_ack, .int_rdata);

  task automatic chk_d(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    chk_d({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic print_verdict;
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic tmo;
    fails++;
    print_verdict;
  endtask

  // Read result appears when the port starts driving the low byte
  always @(posedge clk_sys) begin
    prev_oe <= host_data_bus_oe_n[0];
    if (prev_oe === 1'b1 && host_data_bus_oe_n[0] === 1'b0) begin
      if (exp_q.size() == 0) chk_b(1'b1, 1'b0);
      else begin
        e = exp_q.pop_front();
        chk_d(host_data_bus_out & ~e.oe, e.d & ~e.oe);
        chk_d(host_data_bus_oe_n, e.oe);
      end
    end
  end

  // Straps change one clock after the latch edge, which must not matter
  task automatic rst(input logic [6:0] c);
    rst_n <= 1'b0;
    strap <= c;
    act   <= c[5];
    tick(3);
    rst_n <= 1'b1;
    tick(2);
    strap <= 7'($random(seed));
    tick(2);
  endtask

  task automatic clk_cnt(input logic div);
    int b;
    int m;
    b = 0;
    m = 0;
    repeat (64) begin
      @(negedge clk_sys);
      b += int'(bus_clk_en);
      m += int'(mem_clk_en);
    end
    chk_d(16'(b), div ? 16'h0008 : 16'h0010);
    chk_d(16'(m), 16'h0010);
    // Back onto a rising edge so the next stimulus is not driven at the falling one
    tick();
  endtask

  // One host cycle; ok low marks an unmapped place that reads zero
  task automatic acc(input logic w, m, input logic [17:0] a, input logic [15:0] d,
                     input logic h, input logic ok);
    int n;
    logic [15:0] mk;
    mk = h ? 16'h00ff : 16'hffff;
    adr <= a;
    mrs <= m;
    wd <= d;
    hbe_n <= h;
    dly <= 5'($random(seed)) & 5'h07;
    tick();
    if (!w) exp_q.push_back('{ok ? sh[{m, a}] : 16'h0000, ~mk});
    else if (ok) sh[{m, a}] = (sh[{m, a}] & ~mk) | (d & mk);
    sel_n <= 1'b0;
    if (w) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    n = 0;
    while (wait_out !== act || wait_oe_n !== 1'b0) begin
      tick();
      if (++n > 20) tmo();
    end
    n = 0;
    while (wait_out === act && wait_oe_n === 1'b0) begin
      tick();
      if (++n > 200) tmo();
    end
    if (ok) chk_b(n > int'(dly), 1'b1);
    sel_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    n = 0;
    while (host_data_bus_oe_n !== 16'hffff) begin
      tick();
      if (++n > 20) tmo();
    end
    tick(3);
  endtask

  // Strobe without a valid select or mode must raise nothing
  task automatic probe(input logic s);
    int n;
    n = 0;
    sel_n <= s;
    rd_n <= 1'b0;
    repeat (20) begin
      tick();
      n += int'(int_req === 1'b1 || wait_oe_n === 1'b0);
    end
    chk_d(16'(n), 16'h0000);
    sel_n <= 1'b1;
    rd_n <= 1'b1;
    tick(3);
  endtask

  // Main sequence over three strap settings
  initial begin
    for (int i = 0; i < 3; i++) begin
      rst(cf[i]);
      chk_b(mode_valid, i < 2);
      clk_cnt(cf[i][6]);
      if (i < 2) begin
        foreach (al[j]) begin
          acc(1'b1, al[j][18], al[j][17:0], 16'($random(seed)), 1'b0, 1'b1);
          acc(1'b0, al[j][18], al[j][17:0], 16'h0000, 1'b0, 1'b1);
        end
        acc(1'b1, 1'b0, 18'h0_4010, 16'($random(seed)), 1'b0, 1'b0);
        acc(1'b1, 1'b0, 18'h0_0010, 16'($random(seed)), 1'b1, 1'b1);
        acc(1'b0, 1'b0, 18'h0_0010, 16'h0000, 1'b0, 1'b1);
        acc(1'b0, 1'b0, 18'h0_0010, 16'h0000, 1'b1, 1'b1);
        acc(1'b0, 1'b1, 18'h2_8002, 16'h0000, 1'b0, 1'b0);
        acc(1'b0, 1'b0, 18'h0_4000, 16'h0000, 1'b0, 1'b0);
        probe(1'b1);
      end else probe(1'b0);
    end
    tick(10);
    chk_b(exp_q.size() == 0, 1'b1);
    print_verdict();
  end
endmodule // ahbp_port_tb_top

// ===== ahbp_sync.sv
// Purpose: Two-stage synchroniser for the asynchronous host control strobes
// Assumes: Strobes are active low at the inputs
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module ahbp_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic dev_select_n,
  input  wire logic read_strobe_n,
  input  wire logic low_write_strobe_n,
  input  wire logic high_byte_enable_n,
  ahbp_sync_if.src  sync
);

  typedef struct packed {
    logic [3:0] stg1;
    logic [3:0] stg2;
  } ahbp_sync_st_t;

  ahbp_sync_st_t st_ff;
  ahbp_sync_st_t nxt_st;

  // Invert to active high and shift through two stages
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.stg1 = {~high_byte_enable_n, ~low_write_strobe_n, ~read_strobe_n, ~dev_select_n};
    nxt_st.stg2 = st_ff.stg1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync.sel = st_ff.stg2[0];
  assign sync.rd  = st_ff.stg2[1];
  assign sync.wr  = st_ff.stg2[2];
  assign sync.hbe = st_ff.stg2[3];

endmodule // ahbp_sync

// ===== ahbp_sync_if.sv
// Purpose: Carries synchronised host control levels into the port core
// Assumes: Driven by the synchroniser, read by the port top
// Notes:   All signals are levels in the system clock domain, active high
`timescale 1ns/1ps
interface ahbp_sync_if;
  logic sel;   // Device select asserted
  logic rd;    // Read strobe asserted
  logic wr;    // Low write strobe asserted
  logic hbe;   // High byte enable asserted

  modport src (output sel, output rd, output wr, output hbe);
  modport dst (input sel, input rd, input wr, input hbe);
endinterface : ahbp_sync_if
